// ===== core/adcs_pkg.sv
/*
  adcs_pkg: constants shared by the converter mode sequencer and its
  trigger synchroniser. Register map, field positions, mode codes,
  channel codes and timing counts.
  Assumes a 20 MHz control clock and a 32-bit plain register port.
*/
package adcs_pkg;

  // ==========================================================
  // widths
  localparam int unsigned ADCS_ADDR_W    = 6;
  localparam int unsigned ADCS_DATA_W    = 32;
  localparam int unsigned ADCS_RES_W     = 12;
  localparam int unsigned ADCS_CNT_W     = 8;
  localparam int unsigned ADCS_ACC_W     = 20;
  localparam int unsigned ADCS_TRIG_N    = 8;
  localparam int unsigned ADCS_TSEL_W    = 3;
  localparam int unsigned ADCS_RDY_W     = 10;

  // ==========================================================
  // register byte offsets
  localparam logic [5:0] OFF_PRIMARY    = 6'h00;
  localparam logic [5:0] OFF_SECONDARY  = 6'h04;
  localparam logic [5:0] OFF_TERTIARY   = 6'h08;
  localparam logic [5:0] OFF_START      = 6'h0c;
  localparam logic [5:0] OFF_TRIGGER    = 6'h10;
  localparam logic [5:0] OFF_INT_STATUS = 6'h14;
  localparam logic [5:0] OFF_INT_CLEAR  = 6'h18;
  localparam logic [5:0] OFF_INT_ENABLE = 6'h1c;
  localparam logic [5:0] OFF_RESULT     = 6'h20;
  localparam logic [5:0] OFF_ACCUM      = 6'h24;

  // ==========================================================
  // field positions
  localparam int unsigned BIT_ENABLE     = 0;
  localparam int unsigned POS_MODE       = 1;
  localparam int unsigned POS_SMPL       = 4;
  localparam int unsigned POS_CHAN       = 0;
  localparam int unsigned POS_CNT        = 0;
  localparam int unsigned BIT_ACC_EN     = 8;
  localparam int unsigned BIT_ACC_CLR    = 9;
  localparam int unsigned BIT_START      = 0;
  localparam int unsigned POS_TSEL       = 0;
  localparam int unsigned BIT_TRIG_EN    = 3;
  localparam int unsigned BIT_EOC        = 0;
  localparam int unsigned BIT_ACC_DONE   = 1;
  localparam int unsigned BIT_READY      = 2;

  // ==========================================================
  // operating mode codes
  localparam logic [2:0] MODE_SINGLE     = 3'h0;
  localparam logic [2:0] MODE_REPEAT     = 3'h1;
  localparam logic [2:0] MODE_CONT       = 3'h2;
  localparam logic [2:0] MODE_SEQ_CONT   = 3'h3;
  localparam logic [2:0] MODE_SEQ_SCAN   = 3'h4;
  localparam logic [2:0] MODE_SEQ_REPEAT = 3'h5;
  localparam logic [2:0] MODE_SEQ_INTER  = 3'h6;

  // last external channel code and the channel codes above it
  localparam logic [3:0] CH_EXT_LAST     = 4'hc;
  localparam logic [3:0] CH_SUPPLY_THIRD = 4'hd;
  localparam logic [3:0] CH_TEMP_SENSOR  = 4'he;
  localparam logic [3:0] CH_REF_1V2      = 4'hf;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned READY_TIME_US  = 40;
  localparam int unsigned READY_CYCLES   = (READY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SMPL_CYC_0     = 4'h5;
  localparam logic [3:0]  SMPL_CYC_1     = 4'h6;
  localparam logic [3:0]  SMPL_CYC_2     = 4'h8;
  localparam logic [3:0]  SMPL_CYC_3     = 4'ha;
  localparam logic [4:0]  COMPARE_CYCLES = 5'h13;

endpackage

// ===== core/adcs_trig_if.sv
/*
  adcs_trig_if: trigger selection and the resulting start event between
  the sequencer and the trigger synchroniser.
  Assumes both ends run on the same control clock.
*/
`timescale 1ns/10ps
interface adcs_trig_if;
  import adcs_pkg::*;
  logic [ADCS_TSEL_W-1:0] sel;
  logic                   en;
  logic                   fire;
  modport ctrl (output sel, output en, input fire);
  modport sync (input sel, input en, output fire);
endinterface

// ===== core/adcs_trig_sync.sv
/*
  adcs_trig_sync: three-stage synchroniser for the peripheral trigger
  lines, filtered rising-edge detect and source selection.
  Assumes trigger lines are asynchronous levels held at least three clocks.
*/
`timescale 1ns/10ps
module adcs_trig_sync
  import adcs_pkg::*;
(
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset_n,
  // raw trigger lines
  input  wire logic [ADCS_TRIG_N-1:0] i_trig,
  // selection in, event out
  adcs_trig_if.sync                   trig
);

  logic [ADCS_TRIG_N-1:0] s1_q;
  logic [ADCS_TRIG_N-1:0] s2_q;
  logic [ADCS_TRIG_N-1:0] s3_q;
  logic [ADCS_TRIG_N-1:0] lvl_q;
  logic [ADCS_TRIG_N-1:0] lvl_d;
  logic [ADCS_TRIG_N-1:0] rise_w;
  logic                   fire_q;

  // ==========================================================
  // filtered level: changes only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < ADCS_TRIG_N; g++)
    begin : g_line
      assign lvl_d[g]  = (s2_q[g] == s3_q[g]) ? s2_q[g] : lvl_q[g];
      assign rise_w[g] = lvl_d[g] & ~lvl_q[g];
    end
  endgenerate

  // s1 feeds s2 only; nothing else reads it
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      fire_q <= 1'b0;
    end
    else
    begin
      s1_q   <= i_trig;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      fire_q <= trig.en & rise_w[trig.sel];
    end
  end

  assign trig.fire = fire_q;

  // ==========================================================
  // checks
  trig_select_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    fire_q |-> $past(trig.en) && $past(rise_w[trig.sel]))
    else $error("trigger event without enabled selected edge");

endmodule

// ===== core/adcs_ctrl.sv
/*
  adcs_ctrl: mode sequencer of a 12-bit successive-approximation
  converter. Register file, start/trigger handling, single and repeated
  conversion with accumulation, flags, interrupt request, ready timer.
  Assumes an analog core on the same clock that answers each one-cycle
  start pulse with a one-cycle done pulse and valid result.
*/
// The register addresses and the plain strobed port were decided locally.
// What this block does
// - three-bit mode field: only single and repeated modes run; other codes read back but never start
// - start on software start bit write or selected peripheral trigger
// - four-bit channel select: externals 0-12, supply third, temperature, 1.2V reference
// - single mode: one conversion on the selected channel per start
// - single done: set done flag, store result, clear start, halt
// - repeated mode converts the programmed count plus one; reset value gives one
// - accumulator clear zeroes sum; accumulate enable adds each result
// - repeated mode: each conversion sets done, stores and accumulates
// - keep converting until count reached, then set accumulation done, stop
// - done flag with its enable requests an interrupt
// - accumulation done with its enable requests an interrupt
// - writing zeros to interrupt clear register clears pending flags
// - zero in accumulation-done clear bit clears only that flag
// - start event taken from software-selected peripheral trigger
// - writing zero to enable switches off and halts conversion
// - ready flag set about 40 us after enable rises
// - conversion is sampling phase plus fixed 19-cycle comparison
`timescale 1ns/10ps
module adcs_ctrl
  import adcs_pkg::*;
(
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset_n,
  // register port
  input  wire logic [ADCS_ADDR_W-1:0] i_addr,
  input  wire logic [ADCS_DATA_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [ADCS_DATA_W-1:0] o_rdata,
  // peripheral triggers
  input  wire logic [ADCS_TRIG_N-1:0] i_trig,
  // analog core handshake
  output logic                        o_core_enable,
  output logic                        o_core_start,
  output logic      [3:0]             o_core_channel,
  output logic                        o_core_internal,
  output logic      [3:0]             o_core_sample_cycles,
  output logic      [4:0]             o_core_compare_cycles,
  input  wire logic                   i_core_done,
  input  wire logic [ADCS_RES_W-1:0]  i_core_result,
  // interrupt request
  output logic                        o_irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} adcs_state_e;

  // ==========================================================
  // decode helpers
  function automatic logic adcs_hit(input logic [ADCS_ADDR_W-1:0] a, input logic [5:0] off);
    adcs_hit = (a == off);
  endfunction

  function automatic logic [3:0] adcs_smpl_cycles(input logic [1:0] s);
    case (s)
      2'h0:    adcs_smpl_cycles = SMPL_CYC_0;
      2'h1:    adcs_smpl_cycles = SMPL_CYC_1;
      2'h2:    adcs_smpl_cycles = SMPL_CYC_2;
      default: adcs_smpl_cycles = SMPL_CYC_3;
    endcase
  endfunction

  adcs_trig_if trig_bus ();

  adcs_trig_sync u_trig (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_trig    (i_trig),
    .trig      (trig_bus.sync)
  );

  // registers
  adcs_state_e             st_q, st_d;
  logic                    en_q, ready_q;
  logic [2:0]              mode_q;
  logic [1:0]              smpl_q;
  logic [3:0]              chan_q;
  logic [ADCS_CNT_W-1:0]   cnt_q, conv_q;
  logic                    acc_en_q, start_q, start_d;
  logic [ADCS_TSEL_W-1:0]  tsel_q;
  logic                    ten_q;
  logic                    eoc_q, eoc_d, accdone_q, accdone_d;
  logic                    ie_eoc_q, ie_accdone_q;
  logic [ADCS_RDY_W-1:0]   rdy_cnt_q;
  logic [ADCS_RES_W-1:0]   result_q;
  logic [ADCS_ACC_W-1:0]   acc_q, acc_d, acc_base;
  logic                    core_start_q, core_int_q, irq_q;
  logic [3:0]              core_chan_q, core_smpl_q;
  logic [ADCS_DATA_W-1:0]  rdata_q, rd_mux;

  // ==========================================================
  // write decode
  logic wr_pri, wr_sec, wr_ter, wr_start, wr_trig, wr_icr, wr_ier, acc_clr;
  assign wr_pri   = i_wr && adcs_hit(i_addr, OFF_PRIMARY);
  assign wr_sec   = i_wr && adcs_hit(i_addr, OFF_SECONDARY);
  assign wr_ter   = i_wr && adcs_hit(i_addr, OFF_TERTIARY);
  assign wr_start = i_wr && adcs_hit(i_addr, OFF_START);
  assign wr_trig  = i_wr && adcs_hit(i_addr, OFF_TRIGGER);
  assign wr_icr   = i_wr && adcs_hit(i_addr, OFF_INT_CLEAR);
  assign wr_ier   = i_wr && adcs_hit(i_addr, OFF_INT_ENABLE);
  assign acc_clr  = wr_ter && i_wdata[BIT_ACC_CLR];

  // ==========================================================
  // sequencing conditions; unsupported modes hold the start bit but never run
  logic mode_ok, go, done_ok, cnt_hit, last, set_start, hw_clear;
  assign mode_ok   = (mode_q == MODE_SINGLE) || (mode_q == MODE_REPEAT);
  assign go        = en_q && ready_q && start_q && mode_ok;
  assign done_ok   = (st_q == ST_WAIT) && i_core_done;
  assign cnt_hit   = (conv_q == cnt_q);
  // only repeated mode goes on; a mode changed mid-run stops after this conversion
  assign last      = (mode_q != MODE_REPEAT) || cnt_hit || !start_q;
  // nothing can set the start bit while the module is switched off
  assign set_start = en_q && ((wr_start && i_wdata[BIT_START]) || (trig_bus.fire && ready_q));
  assign hw_clear  = (done_ok && last) || !en_q;

  // setting the start bit wins over any clear in the same cycle
  assign start_d = set_start ? 1'b1 : (wr_start || hw_clear) ? 1'b0 : start_q;

  // flags: hardware set wins over a zero written to the clear register
  assign eoc_d = done_ok ? 1'b1 : (wr_icr && !i_wdata[BIT_EOC]) ? 1'b0 : eoc_q;
  assign accdone_d = (done_ok && mode_q == MODE_REPEAT && cnt_hit) ? 1'b1 :
                     (wr_icr && !i_wdata[BIT_ACC_DONE]) ? 1'b0 : accdone_q;

  // clear and add in one cycle keeps the new sample
  assign acc_base = acc_clr ? '0 : acc_q;
  assign acc_d    = (done_ok && acc_en_q) ? acc_base + ADCS_ACC_W'(i_core_result) : acc_base;

  // ==========================================================
  // state machine next state
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:  if (go) st_d = ST_ISSUE;
      ST_ISSUE: st_d = ST_WAIT;
      ST_WAIT:  if (done_ok) st_d = last ? ST_IDLE : ST_ISSUE;
      default:  st_d = ST_IDLE;
    endcase
    if (!en_q)
      st_d = ST_IDLE;
  end

  // ==========================================================
  // read mux; unmapped addresses read zero
  assign rd_mux =
    adcs_hit(i_addr, OFF_PRIMARY)    ? ADCS_DATA_W'({smpl_q, mode_q, en_q}) :
    adcs_hit(i_addr, OFF_SECONDARY)  ? ADCS_DATA_W'(chan_q) :
    adcs_hit(i_addr, OFF_TERTIARY)   ? ADCS_DATA_W'({acc_en_q, cnt_q}) :
    adcs_hit(i_addr, OFF_START)      ? ADCS_DATA_W'(start_q) :
    adcs_hit(i_addr, OFF_TRIGGER)    ? ADCS_DATA_W'({ten_q, tsel_q}) :
    adcs_hit(i_addr, OFF_INT_STATUS) ? ADCS_DATA_W'({ready_q, accdone_q, eoc_q}) :
    adcs_hit(i_addr, OFF_INT_ENABLE) ? ADCS_DATA_W'({ie_accdone_q, ie_eoc_q}) :
    adcs_hit(i_addr, OFF_RESULT)     ? ADCS_DATA_W'(result_q) :
    adcs_hit(i_addr, OFF_ACCUM)      ? ADCS_DATA_W'(acc_q) : '0;

  // ==========================================================
  // configuration registers
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      en_q <= 1'b0; mode_q <= MODE_SINGLE; smpl_q <= '0; chan_q <= '0;
      cnt_q <= '0; acc_en_q <= 1'b0; tsel_q <= '0; ten_q <= 1'b0;
      ie_eoc_q <= 1'b0; ie_accdone_q <= 1'b0;
    end
    else
    begin
      if (wr_pri)
      begin
        en_q   <= i_wdata[BIT_ENABLE];
        mode_q <= i_wdata[POS_MODE +: 3];
        smpl_q <= i_wdata[POS_SMPL +: 2];
      end
      if (wr_sec) chan_q <= i_wdata[POS_CHAN +: 4];
      if (wr_ter)
      begin
        cnt_q   <= i_wdata[POS_CNT +: ADCS_CNT_W];
        acc_en_q <= i_wdata[BIT_ACC_EN];
      end
      if (wr_trig)
      begin
        tsel_q <= i_wdata[POS_TSEL +: ADCS_TSEL_W];
        ten_q  <= i_wdata[BIT_TRIG_EN];
      end
      if (wr_ier)
      begin
        ie_eoc_q <= i_wdata[BIT_EOC];
        ie_accdone_q <= i_wdata[BIT_ACC_DONE];
      end
    end
  end

  // ==========================================================
  // ready timer: restarts whenever the module is switched off
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rdy_cnt_q <= '0;
      ready_q   <= 1'b0;
    end
    else if (!en_q)
    begin
      rdy_cnt_q <= '0;
      ready_q   <= 1'b0;
    end
    else if (!ready_q)
    begin
      rdy_cnt_q <= rdy_cnt_q + 1'b1;
      ready_q   <= (rdy_cnt_q == ADCS_RDY_W'(READY_CYCLES - 1));
    end
  end

  // ==========================================================
  // sequencer state, flags, results and core drive
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_q <= ST_IDLE; start_q <= 1'b0; conv_q <= '0;
      eoc_q <= 1'b0; accdone_q <= 1'b0; result_q <= '0; acc_q <= '0;
      core_start_q <= 1'b0; core_chan_q <= '0; core_int_q <= 1'b0; core_smpl_q <= SMPL_CYC_0;
      irq_q <= 1'b0; rdata_q <= '0;
    end
    else
    begin
      st_q    <= st_d;
      start_q <= start_d;
      eoc_q   <= eoc_d;
      accdone_q <= accdone_d;
      acc_q   <= acc_d;
      rdata_q <= i_rd ? rd_mux : '0;
      irq_q   <= (eoc_q && ie_eoc_q) || (accdone_q && ie_accdone_q);
      if (st_q == ST_IDLE)
        conv_q <= '0;
      else if (done_ok)
        conv_q <= conv_q + 1'b1;
      if (done_ok)
        result_q <= i_core_result;
      // channel and sampling latched per conversion so core sees stable setup
      core_start_q <= (st_q == ST_ISSUE);
      if (st_q == ST_ISSUE)
      begin
        core_chan_q <= chan_q;
        core_int_q  <= (chan_q > CH_EXT_LAST);
        core_smpl_q <= adcs_smpl_cycles(smpl_q);
      end
    end
  end

  assign trig_bus.sel          = tsel_q;
  assign trig_bus.en           = ten_q;
  assign o_rdata               = rdata_q;
  assign o_core_enable         = en_q;
  assign o_core_start          = core_start_q;
  assign o_core_channel        = core_chan_q;
  assign o_core_internal       = core_int_q;
  assign o_core_sample_cycles  = core_smpl_q;
  assign o_core_compare_cycles = COMPARE_CYCLES;
  assign o_irq                 = irq_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  mode_gate_a: assert property (st_q == ST_ISSUE |-> $past(mode_ok))
    else $error("conversion issued in unsupported mode");
  start_pulse_a: assert property (o_core_start |=> !o_core_start ##0 st_q != ST_ISSUE || !o_core_start)
    else $error("core start longer than one cycle");
  single_stop_a: assert property (done_ok && mode_q == MODE_SINGLE && !wr_start && !trig_bus.fire
    |=> eoc_q && !start_q && st_q == ST_IDLE && result_q == $past(i_core_result))
    else $error("single conversion did not finish cleanly");
  accum_add_a: assert property (done_ok && acc_en_q && !acc_clr
    |=> acc_q == ADCS_ACC_W'($past(acc_q) + ADCS_ACC_W'($past(i_core_result))))
    else $error("result not added into accumulator");
  accum_clear_a: assert property (acc_clr && !done_ok |=> acc_q == '0)
    else $error("accumulator not cleared");
  repeat_end_a: assert property (done_ok && mode_q == MODE_REPEAT && cnt_hit && !set_start
    |=> accdone_q && !start_q ##1 st_q == ST_IDLE)
    else $error("repeated run did not end at count");
  irq_req_a: assert property (eoc_q && ie_eoc_q || accdone_q && ie_accdone_q |=> o_irq)
    else $error("interrupt not requested");
  flag_clear_a: assert property (wr_icr && i_wdata[BIT_ACC_DONE] == 1'b0 && i_wdata[BIT_EOC] && !done_ok
    |=> !accdone_q && eoc_q == $past(eoc_q))
    else $error("accumulation-done clear touched other flag");
  off_halt_a: assert property (!en_q |=> st_q == ST_IDLE && !ready_q && !start_q ##1 !o_core_start)
    else $error("conversion continued while switched off");
  ready_time_a: assert property ($rose(ready_q) |-> rdy_cnt_q == ADCS_RDY_W'(READY_CYCLES) && en_q)
    else $error("ready flag at wrong time");

  single_cov: cover property (done_ok && mode_q == MODE_SINGLE);
  repeat_cov: cover property ($rose(accdone_q));
  trig_cov:   cover property (trig_bus.fire && en_q && ready_q ##[1:4] o_core_start);
  ready_cov:  cover property ($rose(ready_q));

endmodule

// ===== bench/adcs_core_model.sv
/*
  adcs_core_model: behavioural analog converter core for the sequencer bench.
  Assumes the control clock also times the conversion and one-cycle starts.
*/
`timescale 1ns/10ps
module adcs_core_model
  import adcs_pkg::*;
(
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset_n,
  // conversion request
  input  wire logic                  i_start,
  input  wire logic [3:0]            i_sample_cycles,
  input  wire logic [4:0]            i_compare_cycles,
  // bench knobs: extra latency and next sample value
  input  wire logic [3:0]            i_extra,
  input  wire logic [ADCS_RES_W-1:0] i_value,
  // answer
  output logic                       o_done,
  output logic      [ADCS_RES_W-1:0] o_result
);
  int                    left_q;
  logic [ADCS_RES_W-1:0] last_q;

  // ==========================================================
  // conversion timer; between answers the result bus shows the inverse of the
  // last value, so a capture on the wrong cycle never matches by chance
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      left_q   <= 0;
      last_q   <= '0;
      o_done   <= 1'b0;
      o_result <= '1;
    end
    else
    begin
      o_done   <= 1'b0;
      o_result <= ~last_q;
      if (i_start)
        left_q <= int'(i_sample_cycles) + int'(i_compare_cycles) + int'(i_extra) - 1;
      else if (left_q == 1)
      begin
        left_q   <= 0;
        o_done   <= 1'b1;
        o_result <= i_value;
        last_q   <= i_value;
      end
      else if (left_q > 1)
        left_q <= left_q - 1;
    end
  end
endmodule

// ===== bench/adcs_ctrl_tb.sv
/*
  adcs_ctrl_tb: self-checking bench for the converter mode sequencer.
  Assumes adcs_core_model as the analog core and a 20 MHz clock.
*/
`timescale 1ns/10ps
module adcs_ctrl_tb
  import adcs_pkg::*;
;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  trig = '0;
  logic [31:0] rng_q = 32'ha48832d0;
  logic [31:0] rdata;
  logic        core_en, core_start, internal, done, irq;
  logic [3:0]  chan, smpl;
  logic [4:0]  cmp;
  logic [11:0] result;
  logic [3:0]  smpl_len [4] = '{4'h5, 4'h6, 4'h8, 4'ha};
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          n_start = 0;
  int          cyc = 0;
  logic [11:0] res_q [$];

  always #25 mclk = ~mclk;

  adcs_ctrl i_adcs_ctrl (.i_mclk(mclk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_trig(trig), .o_core_enable(core_en),
    .o_core_start(core_start), .o_core_channel(chan), .o_core_internal(internal),
    .o_core_sample_cycles(smpl), .o_core_compare_cycles(cmp), .i_core_done(done),
    .i_core_result(result), .o_irq(irq));

  adcs_core_model i_adcs_core_model (.i_mclk(mclk), .i_reset_n(reset_n), .i_start(core_start),
    .i_sample_cycles(smpl), .i_compare_cycles(cmp), .i_extra(rng_q[3:0]), .i_value(rng_q[15:4]),
    .o_done(done), .o_result(result));

  // ==========================================================
  // xorshift source feeds core latency and values every cycle
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // reference bookkeeping: start pulses, core answers, cycle count
  always @(posedge mclk)
  begin
    rng_q <= xs(rng_q);
    cyc++;
    if (core_start === 1'b1)
      n_start++;
    if (done === 1'b1)
      res_q.push_back(result);
  end

  // ==========================================================
  // register port tasks and checks
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    // read data stand only in the cycle after the strobe; take them at its closing edge
    @(posedge mclk);
    d = rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // polling is bounded; running out ends the run
  task automatic wait_stat(input int b, input int lim);
    logic [31:0] d;
    d = '0;
    for (int k = 0; k < lim && d[b] !== 1'b1; k++)
      rd_reg(OFF_INT_STATUS, d);
    if (d[b] !== 1'b1)
    begin
      n_mismatch++;
      $display("wrong value at %0t: status bit %0d never set", $time, b);
      report_and_stop();
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] d;
    int s, n, t, acc;
    logic [2:0] sel;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rd_reg(OFF_INT_STATUS, d);
    chk(d, 32'h0, "status after reset");
    rd_reg(6'h3c, d);
    chk(d, 32'h0, "unmapped read");
    wr_reg(OFF_PRIMARY, 32'h1);
    t = cyc;
    wait_stat(BIT_READY, 600);
    chk(32'(cyc - t >= 798 && cyc - t <= 806), 32'h1, "ready delay");
    // single runs over every channel code and every sampling length
    for (int k = 0; k < 16; k++)
    begin
      wr_reg(OFF_PRIMARY, 32'((k % 4) << 4) | 32'h1);
      wr_reg(OFF_SECONDARY, 32'(k));
      wr_reg(OFF_INT_CLEAR, 32'h0);
      res_q.delete();
      s = n_start;
      wr_reg(OFF_START, 32'h1);
      wait_stat(BIT_EOC, 40);
      chk(32'(n_start - s), 32'h1, "starts per single run");
      chk(32'(chan), 32'(k), "channel");
      chk(32'(internal), 32'(k >= 13), "internal source");
      chk(32'(smpl), 32'(smpl_len[k % 4]), "sampling length");
      chk(32'(cmp), 32'h13, "compare length");
      rd_reg(OFF_RESULT, d);
      chk(d, 32'(res_q[0]), "single result");
      rd_reg(OFF_START, d);
      chk(d, 32'h0, "start after single");
    end
    // done interrupt raised, then cleared by writing zeros
    wr_reg(OFF_INT_ENABLE, 32'h1);
    wr_reg(OFF_INT_CLEAR, 32'h0);
    wr_reg(OFF_START, 32'h1);
    wait_stat(BIT_EOC, 40);
    chk(32'(irq), 32'h1, "done interrupt");
    wr_reg(OFF_INT_CLEAR, 32'h0);
    rd_reg(OFF_INT_STATUS, d);
    chk(d, 32'h4, "flags after clear");
    chk(32'(irq), 32'h0, "interrupt after clear");
    // repeated runs: shortest count, then a random one
    for (int m = 0; m < 2; m++)
    begin
      n = (m == 0) ? 0 : int'(rng_q[2:0]) + 1;
      wr_reg(OFF_PRIMARY, 32'h3);
      wr_reg(OFF_INT_ENABLE, 32'h2);
      wr_reg(OFF_TERTIARY, 32'h300 | 32'(n));
      wr_reg(OFF_INT_CLEAR, 32'h0);
      res_q.delete();
      s = n_start;
      wr_reg(OFF_START, 32'h1);
      wait_stat(BIT_ACC_DONE, 400);
      chk(32'(n_start - s), 32'(n + 1), "conversions per run");
      acc = 0;
      foreach (res_q[j])
        acc += int'(res_q[j]);
      rd_reg(OFF_ACCUM, d);
      chk(d, 32'(acc), "accumulated sum");
      chk(d / 32'(n + 1), 32'(acc / (n + 1)), "average of run");
      rd_reg(OFF_RESULT, d);
      chk(d, 32'(res_q[$]), "last result");
      chk(32'(irq), 32'h1, "accumulation interrupt");
      rd_reg(OFF_START, d);
      chk(d, 32'h0, "start after run");
      wr_reg(OFF_INT_CLEAR, 32'hfffffffd);
      rd_reg(OFF_INT_STATUS, d);
      chk(d, 32'h5, "only accumulation flag cleared");
    end
    // encoded-only modes read back and never start the core
    for (int m = 2; m < 7; m++)
    begin
      wr_reg(OFF_PRIMARY, 32'(m << 1) | 32'h1);
      rd_reg(OFF_PRIMARY, d);
      chk(d, 32'(m << 1) | 32'h1, "mode readback");
      s = n_start;
      wr_reg(OFF_START, 32'h1);
      repeat (40) @(posedge mclk);
      chk(32'(n_start - s), 32'h0, "no start in other mode");
      wr_reg(OFF_START, 32'h0);
    end
    // trigger: other lines ignored, selected line starts one conversion
    sel = rng_q[2:0];
    wr_reg(OFF_PRIMARY, 32'h1);
    wr_reg(OFF_TRIGGER, 32'h8 | 32'(sel));
    wr_reg(OFF_INT_CLEAR, 32'h0);
    s = n_start;
    trig <= ~(8'h1 << sel);
    repeat (20) @(posedge mclk);
    trig <= 8'h0;
    repeat (20) @(posedge mclk);
    chk(32'(n_start - s), 32'h0, "unselected trigger");
    trig <= 8'h1 << sel;
    repeat (5) @(posedge mclk);
    trig <= 8'h0;
    wait_stat(BIT_EOC, 40);
    chk(32'(n_start - s), 32'h1, "selected trigger");
    // switching off in mid-run halts everything
    wr_reg(OFF_PRIMARY, 32'h3);
    wr_reg(OFF_TERTIARY, 32'h107);
    wr_reg(OFF_START, 32'h1);
    repeat (30) @(posedge mclk);
    wr_reg(OFF_PRIMARY, 32'h0);
    // a start launched on the very edge of the disabling write may still show
    repeat (2) @(posedge mclk);
    s = n_start;
    repeat (60) @(posedge mclk);
    chk(32'(n_start - s), 32'h0, "no start after disable");
    chk(32'(core_en), 32'h0, "core enable off");
    rd_reg(OFF_START, d);
    chk(d, 32'h0, "start after disable");
    report_and_stop();
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    $display("wrong value at %0t: run timed out", $time);
    report_and_stop();
  end
endmodule
